// [core/spaf_pkg.sv]
// Contract
// RULE_01 - Two mode bits select one of four modes
// RULE_02 - Bit 7 maps framing flag or mode bit
// RULE_03 - Invalid stop bit sets sticky framing flag
// RULE_04 - 9-bit filter needs ninth bit and address match
// RULE_05 - 8-bit filter needs valid stop bit
// RULE_06 - Software keeps filter off in shift mode
// RULE_07 - Reception only while receive enable set
// RULE_08 - Transmit ninth bit sent in 9-bit modes
// RULE_09 - Ninth bit or stop bit stored on receive
// RULE_10 - Transmit done at bit eight or stop start
// RULE_11 - Receive done at bit eight or mid stop (the code does not receive in shift mode, so only mid stop applies)
// RULE_12 - Mask zero bits are don't care
// RULE_13 - Mask one bits must equal station address
// RULE_14 - Broadcast is address OR mask, zeros ignored
// RULE_15 - Frame: start low, eight LSB first, ninth, stop
// RULE_16 - Variable modes use tick, fixed mode divides clock
package spaf_pkg;
  localparam logic [31:0] SPAF_REG_CTRL = 32'h0000_0098;
  localparam logic [31:0] SPAF_REG_DATA = 32'h0000_009C;
  localparam logic [31:0] SPAF_REG_ADDR = 32'h0000_00A0;
  localparam logic [31:0] SPAF_REG_MASK = 32'h0000_00A4;
  localparam logic [31:0] SPAF_REG_AUX = 32'h0000_00A8;
  localparam logic [31:0] SPAF_REG_IRQ_STAT = 32'h0000_00AC;
  localparam logic [31:0] SPAF_REG_IRQ_MASK = 32'h0000_00B0;
  localparam logic [7:0] SPAF_CTRL_RST = 8'h00;
  localparam int SPAF_B_TOP = 7;
  localparam int SPAF_B_M1 = 6;
  localparam int SPAF_B_FILT = 5;
  localparam int SPAF_B_REN = 4;
  localparam int SPAF_B_TB8 = 3;
  localparam int SPAF_B_RB8 = 2;
  localparam int SPAF_B_TI = 1;
  localparam int SPAF_B_RI = 0;
  localparam int SPAF_B_SEL = 0;
  localparam logic [4:0] SPAF_FIXED_DIV = 5'h1F;
  localparam logic [3:0] SPAF_OVS_LAST = 4'hF;
  localparam logic [3:0] SPAF_OVS_MID = 4'h7;
  localparam logic [3:0] SPAF_BITS8 = 4'h8;
  localparam logic [3:0] SPAF_BITS9 = 4'h9;
  localparam logic [1:0] SPAF_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPAF_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0]
  {
    SPAF_M_SHIFT = 2'b00,
    SPAF_M_ASYNC8 = 2'b01,
    SPAF_M_FIXED9 = 2'b10,
    SPAF_M_VAR9 = 2'b11
  } spaf_mode_t;
  typedef struct packed
  {
    logic txd;
    logic rxd_oe;
    logic rxd_out;
  } spaf_pins_t;
endpackage

// [core/spaf_rxcore.sv]
`timescale 1ns/1ps
module spaf_rxcore
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire spaf_pkg::spaf_mode_t mode,
  input wire logic enable,
  input wire logic tick,
  input wire logic rxd_s,
  // Result
  output logic done,
  output logic [7:0] data,
  output logic ninth,
  output logic stop_ok
);
  import spaf_pkg::*;
  logic busy_q;
  logic [3:0] ovs_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic nine;
  logic at_mid;
  logic last_data;
  assign nine = mode[1];
  assign at_mid = tick && (ovs_q == SPAF_OVS_MID);
  assign last_data = bit_q == (nine ? SPAF_BITS9 : SPAF_BITS8);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q <= 1'b0;
      ovs_q <= 4'h0;
      bit_q <= 4'h0;
      sh_q <= 9'h000;
      done <= 1'b0;
      data <= 8'h00;
      ninth <= 1'b0;
      stop_ok <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy_q)
      begin
        ovs_q <= 4'h0;
        bit_q <= 4'h0;
        if (enable && tick && !rxd_s) // RULE_07 RULE_15
          busy_q <= 1'b1;
      end
      else if (tick)
      begin
        ovs_q <= ovs_q + 4'h1;
        if (at_mid)
        begin
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'h0 && rxd_s)
            busy_q <= 1'b0;
          else if (bit_q != 4'h0 && !last_data && bit_q < SPAF_BITS9)
            sh_q <= {rxd_s, sh_q[8:1]}; // RULE_15
          else if (bit_q == 4'h0)
            sh_q <= 9'h000;
          if (bit_q > 4'h0 && last_data)
          begin
            sh_q <= {rxd_s, sh_q[8:1]};
          end
          if (bit_q == (nine ? SPAF_BITS9 : SPAF_BITS8) + 4'h1)
          begin
            busy_q <= 1'b0; // RULE_11
            done <= 1'b1;
            stop_ok <= rxd_s;
            data <= nine ? sh_q[7:0] : sh_q[8:1];
            ninth <= nine ? sh_q[8] : rxd_s; // RULE_09
          end
        end
      end
    end
  end
endmodule

// [core/spaf_top.sv]
`timescale 1ns/1ps
module spaf_top
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial
  input wire logic baud_tick,
  input wire logic rxd_in,
  output spaf_pkg::spaf_pins_t pins,
  // Interrupt
  output logic irq
);
  import spaf_pkg::*;
  logic top_mode_q, m1_q, filt_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, fe_q, sel_q;
  logic [7:0] rbuf_q, station_address_q, smask_q;
  logic [1:0] ist_q, imsk_q;
  logic [1:0] rx_sync_q;
  logic aw_q, w_q;
  logic [31:0] awa_q, wd_q;
  logic [4:0] div_q;
  logic [3:0] tov_q, tbit_q;
  logic [9:0] tsh_q;
  logic tbusy_q, tx_q, sclk_q;
  spaf_mode_t mode;
  logic tick, fixed_tick, sub_tick, rx_done, rx_ninth, rx_stop;
  logic [7:0] rx_data, given, bcast;
  logic addr_hit, accept, set_ri, set_ti, wr_go, rd_go;
  logic wr_ctrl, wr_data, wr_addr, wr_mask, wr_aux, wr_ist, wr_imsk, rd_ok, wr_ok;
  logic [7:0] ctrl_rd, wb;
  logic [31:0] rd_mux;
  logic [3:0] tx_last, tx_end;
  assign mode = spaf_mode_t'({top_mode_q, m1_q}); // RULE_01
  assign fixed_tick = div_q == SPAF_FIXED_DIV;
  assign tick = (mode == SPAF_M_FIXED9) ? fixed_tick : baud_tick; // RULE_16
  assign sub_tick = tick;
  assign given = (rx_data & smask_q) ^ (station_address_q & smask_q); // RULE_12 RULE_13
  assign bcast = (station_address_q | smask_q); // RULE_14
  assign addr_hit = (given == 8'h00) || ((rx_data & bcast) == bcast); // RULE_14
  assign accept = !filt_q || (mode[1] ? (rx_ninth && addr_hit) : rx_stop); // RULE_04 RULE_05
  assign set_ri = rx_done && accept && mode != SPAF_M_SHIFT;
  // Shift mode stops after eight data bits; async frames flag at the start of the stop bit.
  assign tx_last = (mode == SPAF_M_SHIFT) ? SPAF_BITS8 - 4'h1 : (mode[1] ? SPAF_BITS9 : SPAF_BITS8);
  assign tx_end = (mode == SPAF_M_SHIFT) ? tx_last : tx_last + 4'h1;
  assign set_ti = tbusy_q && tick && tov_q == SPAF_OVS_LAST && tbit_q == tx_last; // RULE_10
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign wr_ctrl = wr_go && awa_q == SPAF_REG_CTRL;
  assign wr_data = wr_go && awa_q == SPAF_REG_DATA;
  assign wr_addr = wr_go && awa_q == SPAF_REG_ADDR;
  assign wr_mask = wr_go && awa_q == SPAF_REG_MASK;
  assign wr_aux = wr_go && awa_q == SPAF_REG_AUX;
  assign wr_ist = wr_go && awa_q == SPAF_REG_IRQ_STAT;
  assign wr_imsk = wr_go && awa_q == SPAF_REG_IRQ_MASK;
  assign wr_ok = wr_ctrl | wr_data | wr_addr | wr_mask | wr_aux | wr_ist | wr_imsk;
  assign wb = wd_q[7:0];
  assign ctrl_rd = {sel_q ? fe_q : top_mode_q, m1_q, filt_q, ren_q, tb8_q, rb8_q, ti_q, ri_q}; // RULE_02
  assign rd_ok = s_axi_araddr == SPAF_REG_CTRL || s_axi_araddr == SPAF_REG_DATA
    || s_axi_araddr == SPAF_REG_ADDR || s_axi_araddr == SPAF_REG_MASK || s_axi_araddr == SPAF_REG_AUX
    || s_axi_araddr == SPAF_REG_IRQ_STAT || s_axi_araddr == SPAF_REG_IRQ_MASK;
  assign rd_mux = (s_axi_araddr == SPAF_REG_CTRL) ? {24'h000000, ctrl_rd}
    : (s_axi_araddr == SPAF_REG_DATA) ? {24'h000000, rbuf_q}
    : (s_axi_araddr == SPAF_REG_ADDR) ? {24'h000000, station_address_q}
    : (s_axi_araddr == SPAF_REG_MASK) ? {24'h000000, smask_q}
    : (s_axi_araddr == SPAF_REG_AUX) ? {31'h00000000, sel_q}
    : (s_axi_araddr == SPAF_REG_IRQ_STAT) ? {30'h00000000, ist_q}
    : (s_axi_araddr == SPAF_REG_IRQ_MASK) ? {30'h00000000, imsk_q} : 32'h00000000;
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq = |(ist_q & imsk_q);
  // In shift mode this pin carries the clock, which rises mid-bit while the data stand still.
  assign pins.txd = (mode == SPAF_M_SHIFT) ? (tbusy_q ? sclk_q : 1'b1) : tx_q;
  assign pins.rxd_oe = (mode == SPAF_M_SHIFT) && tbusy_q;
  assign pins.rxd_out = tx_q;
  spaf_rxcore u_rx
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode),
    .enable(ren_q && mode != SPAF_M_SHIFT),
    .tick(sub_tick),
    .rxd_s(rx_sync_q[1]),
    .done(rx_done),
    .data(rx_data),
    .ninth(rx_ninth),
    .stop_ok(rx_stop)
  );
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 32'h00000000;
      wd_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SPAF_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= SPAF_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid && !aw_q)
      begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q)
      begin
        w_q <= 1'b1;
        wd_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
      end
      if (wr_go)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? SPAF_RESP_OKAY : SPAF_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? SPAF_RESP_OKAY : SPAF_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {top_mode_q, m1_q, filt_q, ren_q, tb8_q} <= SPAF_CTRL_RST[7:3];
      {rb8_q, ti_q, ri_q, fe_q, sel_q} <= 5'h00;
      rbuf_q <= 8'h00;
      station_address_q <= 8'h00;
      smask_q <= 8'h00;
      ist_q <= 2'h0;
      imsk_q <= 2'h0;
      rx_sync_q <= 2'h3;
      div_q <= 5'h00;
    end
    else
    begin
      rx_sync_q <= {rx_sync_q[0], rxd_in};
      div_q <= div_q + 5'h01; // RULE_16
      if (wr_ctrl)
      begin
        if (sel_q)
          fe_q <= wb[SPAF_B_TOP]; // RULE_02
        else
          top_mode_q <= wb[SPAF_B_TOP];
        m1_q <= wb[SPAF_B_M1];
        filt_q <= wb[SPAF_B_FILT]; // RULE_06
        ren_q <= wb[SPAF_B_REN];
        tb8_q <= wb[SPAF_B_TB8];
        rb8_q <= wb[SPAF_B_RB8];
        ti_q <= wb[SPAF_B_TI];
        ri_q <= wb[SPAF_B_RI];
      end
      if (wr_addr)
        station_address_q <= wb;
      if (wr_mask)
        smask_q <= wb;
      if (wr_aux)
        sel_q <= wb[SPAF_B_SEL];
      if (wr_imsk)
        imsk_q <= wb[1:0];
      if (wr_ist)
        ist_q <= ist_q & ~wb[1:0];
      if (rx_done && !rx_stop && mode != SPAF_M_SHIFT)
        fe_q <= 1'b1; // RULE_03
      if (set_ri)
      begin
        ri_q <= 1'b1; // RULE_11
        rbuf_q <= rx_data;
        rb8_q <= rx_ninth; // RULE_09
        ist_q[SPAF_B_RI] <= 1'b1;
      end
      if (set_ti)
      begin
        ti_q <= 1'b1; // RULE_10
        ist_q[SPAF_B_TI] <= 1'b1;
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tbusy_q <= 1'b0;
      tov_q <= 4'h0;
      tbit_q <= 4'h0;
      tsh_q <= 10'h3FF;
      tx_q <= 1'b1;
      sclk_q <= 1'b0;
    end
    else if (wr_data && !tbusy_q)
    begin
      // Shift mode sends bits without start; async frames open low.
      tbusy_q <= 1'b1;
      tov_q <= 4'h0;
      tbit_q <= 4'h0;
      tsh_q <= {1'b1, tb8_q, wb}; // RULE_08
      tx_q <= (mode == SPAF_M_SHIFT) ? wb[0] : 1'b0; // RULE_15
      sclk_q <= 1'b1;
    end
    else if (tbusy_q && tick)
    begin
      tov_q <= tov_q + 4'h1;
      sclk_q <= tov_q[3];
      if (tov_q == SPAF_OVS_LAST)
      begin
        tbit_q <= tbit_q + 4'h1;
        tx_q <= (mode == SPAF_M_SHIFT) ? tsh_q[1] : tsh_q[0];
        tsh_q <= {1'b1, tsh_q[9:1]};
        if (mode != SPAF_M_SHIFT && !mode[1] && tbit_q == SPAF_BITS8)
          tx_q <= 1'b1;
        if (tbit_q == tx_end)
        begin
          tbusy_q <= 1'b0;
          tx_q <= 1'b1;
        end
      end
    end
  end
endmodule

// [bench/spaf_assertions.sv]
`timescale 1ns/1ps
module spaf_assertions
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Serial and interrupt
  input wire spaf_pkg::spaf_pins_t pins,
  input wire logic irq
);
  import spaf_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("Read answer late.");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("Read answer dropped.");
  property p_r_data;
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_data: assert property (p_r_data) else $error("Read data moved.");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("Write answer dropped.");
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("Write answer late.");
  property p_resp;
    s_axi_rvalid |-> s_axi_rresp == SPAF_RESP_OKAY || s_axi_rresp == SPAF_RESP_SLVERR;
  endproperty
  a_resp: assert property (p_resp) else $error("Bad read response.");
  property p_idle;
    $rose(aresetn) |-> pins.txd;
  endproperty
  a_idle: assert property (p_idle) else $error("Line not idle high.");
  // Shift mode is excluded because its line timing differs.
  property p_start;
    $fell(pins.txd) && !pins.rxd_oe |-> !pins.txd [*8];
  endproperty
  a_start: assert property (p_start) else $error("Start bit too short.");
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == SPAF_RESP_SLVERR);
  c_tx: cover property ($fell(pins.txd));
endmodule
bind spaf_top spaf_assertions chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pins, .irq);

// [bench/spaf_node.sv]
`timescale 1ns/1ps
module spaf_node
(
  // Clock
  input wire logic aclk,
  // Serial lines
  output logic rxd_in,
  input wire logic txd
);
  int i;
  initial rxd_in = 1'h1;
  // Bits go out least significant first; the last one is the stop bit.
  task send(input logic [9:0] b, input int n, input int per);
    rxd_in <= 1'h0;
    repeat (per) @(posedge aclk);
    for (i = 0; i < n; i++)
    begin
      rxd_in <= b[i];
      repeat (per) @(posedge aclk);
    end
    rxd_in <= 1'h1;
  endtask
  task capture(output logic [9:0] g, input int n, input int per);
    g = 10'h0;
    for (i = 0; i < 20000 && txd; i++)
      @(posedge aclk);
    repeat (per / 2) @(posedge aclk);
    for (i = 0; i < n; i++)
    begin
      repeat (per) @(posedge aclk);
      g[i] = txd;
    end
  endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("Error at %0t: %0h vs %0h", $time, g, e); end end
module tb;
  import spaf_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic baud_tick = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, rxd_in, h, da, dw;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [9:0] got;
  logic [8:0] ftab [5] = '{9'h1F0, 9'h0F0, 9'h1F2, 9'h1F5, 9'h1FF};
  logic [4:0] fx = 5'h19;
  spaf_pins_t pins;
  int err_count = 0, checked = 0, k;
  spaf_top dut_u
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .baud_tick(baud_tick),
    .rxd_in(rxd_in),
    .pins(pins),
    .irq(irq)
  );
  spaf_node node_u (.aclk, .rxd_in, .txd(pins.txd));
  always #50 aclk = ~aclk;
  // Tick every other cycle gives a 32-cycle bit time.
  always @(posedge aclk) baud_tick <= ~baud_tick;
  task complete_run;
    $display("Errors %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function logic sig(int c);
    return c == 0 ? s_axi_arready : c == 1 ? s_axi_rvalid : s_axi_bvalid;
  endfunction
  // Ready is combinational, so it is looked at before the edge that takes it.
  task waitfor(input int c);
    h = 1'h0;
    for (k = 0; k < 100 && !h; k++)
    begin
      @(negedge aclk);
      h = sig(c);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
    end
    if (!h)
    begin
      err_count++;
      complete_run();
    end
  endtask
  task wr(input logic [31:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    da = 1'h0;
    dw = 1'h0;
    for (k = 0; k < 100 && !(da && dw); k++)
    begin
      @(negedge aclk);
      da = da | s_axi_awready;
      dw = dw | s_axi_wready;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'h0;
      if (dw) s_axi_wvalid <= 1'h0;
    end
    if (!(da && dw))
    begin
      err_count++;
      complete_run();
    end
    // A late bready makes the response wait once, so its hold check is reached.
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'h1;
    waitfor(2);
    s_axi_bready <= 1'h0;
  endtask
  task rd_reg(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    waitfor(0);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    waitfor(1);
    s_axi_rready <= 1'h0;
  endtask
  task rchk(input logic [31:0] a, m, e);
    rd_reg(a);
    `CHK(rd & m, e)
  endtask
  task ti_poll;
    rd = 32'h0;
    for (int j = 0; j < 200 && !rd[1]; j++)
      rd_reg(SPAF_REG_CTRL);
    `CHK(rd[1], 1'h1)
  endtask
  task txchk(input logic [7:0] c, d, input int per, input logic [9:0] e);
    wr(SPAF_REG_CTRL, c);
    fork
      node_u.capture(got, 10, per);
      wr(SPAF_REG_DATA, d);
    join
    `CHK(got, e)
    ti_poll();
    // The stop bit must end before the next mode or data write: a mode write changes the frame, a data write is lost.
    repeat (per) @(posedge aclk);
  endtask
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk(SPAF_REG_CTRL, 32'hFF, 32'h0);
    rchk(32'h0000_0004, 32'hFFFF_FFFF, 32'h0);
    `CHK(rr, SPAF_RESP_SLVERR)
    wr(SPAF_REG_CTRL, 8'h50);
    node_u.send(10'h1A5, 9, 32);
    rchk(SPAF_REG_CTRL, 32'hFF, 32'h55);
    rchk(SPAF_REG_DATA, 32'hFF, 32'hA5);
    `CHK(irq, 1'h0)
    wr(SPAF_REG_IRQ_MASK, 8'h01);
    `CHK(irq, 1'h1)
    wr(SPAF_REG_IRQ_STAT, 8'h01);
    `CHK(irq, 1'h0)
    wr(SPAF_REG_AUX, 8'h01);
    node_u.send(10'h0A5, 9, 32);
    rchk(SPAF_REG_CTRL, 32'h80, 32'h80);
    // With access select set, bit 7 writes the error flag and leaves the mode alone.
    wr(SPAF_REG_CTRL, 8'h50);
    rchk(SPAF_REG_CTRL, 32'h80, 32'h0);
    wr(SPAF_REG_CTRL, 8'h70);
    node_u.send(10'h0A5, 9, 32);
    rchk(SPAF_REG_CTRL, 32'h1, 32'h0);
    node_u.send(10'h1A5, 9, 32);
    rchk(SPAF_REG_CTRL, 32'h1, 32'h1);
    wr(SPAF_REG_AUX, 8'h00);
    rchk(SPAF_REG_CTRL, 32'h80, 32'h0);
    wr(SPAF_REG_CTRL, 8'h40);
    node_u.send(10'h1A5, 9, 32);
    rchk(SPAF_REG_CTRL, 32'hFF, 32'h40);
    wr(SPAF_REG_ADDR, 8'hF1);
    wr(SPAF_REG_MASK, 8'hFA);
    for (int i = 0; i < 5; i++)
    begin
      wr(SPAF_REG_CTRL, 8'hF0);
      node_u.send({1'h1, ftab[i]}, 10, 32);
      rchk(SPAF_REG_CTRL, 32'h1, {31'h0, fx[i]});
    end
    txchk(8'hC8, 8'h3C, 32, 10'h33C);
    txchk(8'h80, 8'h81, 512, 10'h281);
    wr(SPAF_REG_CTRL, 8'h00);
    wr(SPAF_REG_DATA, 8'h55);
    ti_poll();
    complete_run();
  end
endmodule
